// ===== common/uart_sc_pkg.sv
// shared constants and types of the serial transceiver with card support
// assumes a 32-bit apb with byte addresses, registers one word each
package uart_sc_pkg;
  localparam int QUEUE_DEPTH = 16;
  localparam int OVERSAMPLE = 16;
  localparam int HALF_BIT_TICKS = 8;
  localparam int CARD_DIV_W = 16;
  // register byte offsets
  localparam logic [7:0] OFS_BAUD = 8'h00;
  localparam logic [7:0] OFS_TX_HOLD = 8'h04;
  localparam logic [7:0] OFS_RX_HOLD = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_IER = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_GUARD = 8'h18;
  localparam logic [7:0] OFS_GAP = 8'h1c;
  localparam logic [7:0] OFS_TX_FLUSH = 8'h20;
  localparam logic [7:0] OFS_RX_FLUSH = 8'h24;
  localparam logic [7:0] OFS_ROUTE = 8'h28;
  localparam logic [7:0] OFS_CARD_DIV = 8'h2c;
  // line_control fields
  localparam int CR_FIFO_EN = 10;
  localparam int CR_CARD_MODE = 9;
  localparam int CR_RX_ON = 8;
  localparam int CR_RUN = 7;
  localparam int CR_LOOP = 6;
  localparam int CR_ODD = 5;
  localparam int CR_STOP_LO = 3;
  localparam int CR_MODE_LO = 0;
  // line_flags fields
  localparam int SR_TX_FULL = 9;
  localparam int SR_RX_HALF = 8;
  localparam int SR_IDLE_GAP = 7;
  localparam int SR_PEND_GAP = 6;
  localparam int SR_LOST = 5;
  localparam int SR_STOP_FAULT = 4;
  localparam int SR_CHECK_FAULT = 3;
  localparam int SR_TX_HALF_FREE = 2;
  localparam int SR_DRAINED = 1;
  localparam int SR_RX_AVAIL = 0;
  // reset values
  localparam logic [15:0] BAUD_RESET = 16'h0001;
  localparam logic [15:0] FLAGS_RESET = 16'h0006;
  localparam logic [7:0] GUARD_RESET = 8'h00;
  localparam logic [7:0] GAP_RESET = 8'h00;
  // frame modes
  localparam logic [2:0] MODE_8 = 3'h1;
  localparam logic [2:0] MODE_7P = 3'h3;
  localparam logic [2:0] MODE_9 = 3'h4;
  localparam logic [2:0] MODE_8W = 3'h5;
  localparam logic [2:0] MODE_8P = 3'h7;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_BITS, TX_STOP} tx_phase_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_phase_t;
endpackage : uart_sc_pkg

// ===== logic/queue_mem.sv
// small queue storage, one write port, registered read data
// assumes the owner keeps pointers and passes the next read address
module queue_mem import uart_sc_pkg::*; #(
  parameter int WIDTH = 9,
  parameter int DEPTH = QUEUE_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rdata_reg;
  } mem_state_t;
  mem_state_t r;
  mem_state_t n;
  always_comb begin
    n = r;
    if (we) begin
      n.mem[waddr] = wdata;
    end
    // bypass so a word written into an empty queue is seen at once
    n.rdata_reg = (we && waddr == raddr) ? wdata : r.mem[raddr];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign rdata = r.rdata_reg;
endmodule : queue_mem

// ===== logic/card_clock_gen.sv
// card clock divider: output toggles every div cycles of pclk
// assumes div is steady while the card is clocked; div of zero stops it low
module card_clock_gen import uart_sc_pkg::*; #(
  parameter int W = CARD_DIV_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] div,
  output logic card_clk
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic clk_reg;
  } div_state_t;
  div_state_t r;
  div_state_t n;
  always_comb begin
    n = r;
    if (div == '0) begin
      n.cnt = '0;
      n.clk_reg = 1'b0;
    end else if (r.cnt >= div - W'(1)) begin
      n.cnt = '0;
      n.clk_reg = !r.clk_reg;
    end else begin
      n.cnt = r.cnt + W'(1);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign card_clk = r.clk_reg;
endmodule : card_clock_gen

// ===== logic/uart_sc_core.sv
// serial transceiver with queues, status, guard time, gap timeout and card hookup
// assumes apb master on pclk; card_data_in_pin is asynchronous and synchronised here
//
// Added by the designer: the APB slave port.
module uart_sc_core import uart_sc_pkg::*; #(
  parameter int DEPTH = QUEUE_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic card_data_in_pin,
  output logic serial_out,
  output logic card_data_out_oe,
  output logic card_clock_pin,
  output logic irq
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("queue depth must be a power of two, at least 4");
  end

  typedef struct packed {
    logic [15:0] baud_reload;
    logic [15:0] baud_cnt;
    logic [10:0] ctrl;
    logic [8:0] ier;
    logic [7:0] guard_cfg;
    logic [7:0] gap_cfg;
    logic route;
    logic [15:0] card_div;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [3:0] os_cnt;
    logic [AW-1:0] txq_wr;
    logic [AW-1:0] txq_rd;
    logic [CW-1:0] txq_cnt;
    logic [AW-1:0] rxq_wr;
    logic [AW-1:0] rxq_rd;
    logic [CW-1:0] rxq_cnt;
    logic [CW-1:0] ferr_cnt;
    logic [CW-1:0] perr_cnt;
    tx_phase_t tx_phase;
    logic [4:0] tx_tick;
    logic [3:0] tx_bit;
    logic [8:0] tx_shift;
    logic [7:0] guard_cnt;
    rx_phase_t rx_phase;
    logic [3:0] rx_tick;
    logic [3:0] rx_bit;
    logic [8:0] rx_shift;
    logic [7:0] gap_cnt;
    logic gap_armed;
    logic idle_gap;
    logic pend_gap;
    logic lost;
    logic rx_meta;
    logic rx_sync;
    logic txd;
    logic data_oe;
    logic clk_pin;
    logic irq_reg;
  } core_state_t;

  function automatic core_state_t reset_state();
    core_state_t s;
    s = '0;
    s.baud_reload = BAUD_RESET;
    s.baud_cnt = BAUD_RESET;
    s.guard_cfg = GUARD_RESET;
    s.gap_cfg = GAP_RESET;
    s.rx_meta = 1'b1;
    s.rx_sync = 1'b1;
    s.txd = 1'b1;
    return s;
  endfunction : reset_state

  localparam core_state_t STATE_RESET = reset_state();

  function automatic logic [3:0] frame_last(input logic [2:0] mode);
    return (mode == MODE_7P || mode == MODE_8) ? 4'h7 : 4'h8;
  endfunction : frame_last

  // direct convention only, software flips inverse data
  function automatic logic [8:0] tx_frame(input logic [2:0] mode, input logic odd,
                                          input logic [8:0] d);
    case (mode)
      MODE_7P: tx_frame = {1'b0, ^d[6:0] ^ odd, d[6:0]};
      MODE_8P: tx_frame = {^d[7:0] ^ odd, d[7:0]};
      MODE_8: tx_frame = {1'b0, d[7:0]};
      default: tx_frame = d;
    endcase
  endfunction : tx_frame

  function automatic logic check_bad(input logic [2:0] mode, input logic odd,
                                     input logic [8:0] w);
    case (mode)
      MODE_7P: check_bad = w[7] != (^w[6:0] ^ odd);
      MODE_8P: check_bad = w[8] != (^w[7:0] ^ odd);
      default: check_bad = 1'b0;
    endcase
  endfunction : check_bad

  function automatic logic reg_hit(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= OFS_CARD_DIV;
  endfunction : reg_hit

  core_state_t r;
  core_state_t n;
  logic acc, done, wr, rd, run, tick, bit_tick, line, txd_now;
  logic tx_push, tx_pop, rx_push, rx_pop, ferr_new, perr_new;
  logic [CW-1:0] cap;
  logic [15:0] flags;
  logic [15:0] rdmux;
  logic [8:0] rx_word;
  logic [8:0] txq_head;
  logic [10:0] rxq_head;
  logic [4:0] stop_last;
  logic card_clk;

  queue_mem #(.WIDTH(9), .DEPTH(DEPTH)) u_tx_queue (
    .pclk(pclk),
    .presetn(presetn),
    .we(tx_push),
    .waddr(r.txq_wr),
    .wdata(pwdata[8:0]),
    .raddr(n.txq_rd),
    .rdata(txq_head)
  );

  queue_mem #(.WIDTH(11), .DEPTH(DEPTH)) u_rx_queue (
    .pclk(pclk),
    .presetn(presetn),
    .we(rx_push),
    .waddr(r.rxq_wr),
    .wdata({perr_new, ferr_new, rx_word}),
    .raddr(n.rxq_rd),
    .rdata(rxq_head)
  );

  // divider separate from the baud counter
  card_clock_gen #(.W(CARD_DIV_W)) u_card_clock (
    .pclk(pclk),
    .presetn(presetn),
    .div(r.card_div),
    .card_clk(card_clk)
  );

  always_comb begin
    n = r;
    acc = psel & penable;
    done = acc & r.pready_reg;
    wr = done & pwrite;
    rd = done & !pwrite;
    run = r.ctrl[CR_RUN];
    tick = 1'b0;
    bit_tick = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    // loopback feeds the receiver from the registered transmit line
    line = r.ctrl[CR_LOOP] ? r.txd : r.rx_sync;
    rx_word = (frame_last(r.ctrl[2:0]) == 4'h7) ? {1'b0, r.rx_shift[8:1]} : r.rx_shift;
    ferr_new = !line;
    perr_new = check_bad(r.ctrl[2:0], r.ctrl[CR_ODD], rx_word);
    stop_last = {r.ctrl[4:3], 3'h7};
    // with the queue switched off each side holds one character
    cap = r.ctrl[CR_FIFO_EN] ? CW'(DEPTH) : CW'(1);

    flags = 16'h0000;
    flags[SR_TX_FULL] = r.txq_cnt == CW'(DEPTH);
    flags[SR_RX_HALF] = r.rxq_cnt > CW'(DEPTH / 2);
    flags[SR_IDLE_GAP] = r.idle_gap;
    flags[SR_PEND_GAP] = r.pend_gap;
    flags[SR_LOST] = r.lost;
    flags[SR_STOP_FAULT] = r.ferr_cnt != '0;
    flags[SR_CHECK_FAULT] = r.perr_cnt != '0;
    flags[SR_TX_HALF_FREE] = r.txq_cnt <= CW'(DEPTH / 2);
    flags[SR_DRAINED] = r.tx_phase == TX_IDLE && r.guard_cnt == 8'h00;
    flags[SR_RX_AVAIL] = r.rxq_cnt != '0;

    case (paddr)
      OFS_BAUD: rdmux = r.baud_cnt;
      OFS_RX_HOLD: rdmux = {6'h00, rxq_head[9:0]};
      OFS_CTRL: rdmux = {5'h00, r.ctrl};
      OFS_IER: rdmux = {7'h00, r.ier};
      OFS_FLAGS: rdmux = flags;
      OFS_GUARD: rdmux = {8'h00, r.guard_cfg};
      OFS_GAP: rdmux = {8'h00, r.gap_cfg};
      OFS_ROUTE: rdmux = {15'h0000, r.route};
      OFS_CARD_DIV: rdmux = r.card_div;
      default: rdmux = 16'h0000;
    endcase

    // one wait state: answer is registered, then completes
    n.pready_reg = acc & !r.pready_reg;
    if (acc & !r.pready_reg) begin
      n.prdata_reg = {16'h0000, rdmux};
      n.pslverr_reg = !reg_hit(paddr);
    end
    if (rd && paddr == OFS_FLAGS) begin
      n.lost = 1'b0;
    end
    if (rd && paddr == OFS_RX_HOLD && r.rxq_cnt != '0) begin
      rx_pop = 1'b1;
    end
    if (wr) begin
      case (paddr)
        OFS_BAUD: begin
          n.baud_reload = pwdata[15:0];
          n.baud_cnt = pwdata[15:0];
        end
        OFS_TX_HOLD: tx_push = r.txq_cnt < cap;
        OFS_CTRL: n.ctrl = pwdata[10:0];
        OFS_IER: n.ier = pwdata[8:0];
        OFS_GUARD: n.guard_cfg = pwdata[7:0];
        OFS_GAP: n.gap_cfg = pwdata[7:0];
        OFS_ROUTE: n.route = pwdata[0];
        OFS_CARD_DIV: n.card_div = pwdata[15:0];
        default: ;
      endcase
    end

    // baud counter and everything after it halt while run is low
    if (run) begin
      if (r.baud_cnt == 16'h0000) begin
        tick = 1'b1;
        n.baud_cnt = r.baud_reload;
      end else begin
        n.baud_cnt = r.baud_cnt - 16'h0001;
      end
    end
    if (tick) begin
      n.os_cnt = r.os_cnt + 4'h1;
      bit_tick = r.os_cnt == 4'(OVERSAMPLE - 1);
    end

    // transmitter
    if (tick) begin
      n.tx_tick = r.tx_tick + 5'h01;
      unique case (r.tx_phase)
        TX_IDLE: begin
          n.tx_tick = 5'h00;
          if (r.txq_cnt != '0) begin
            tx_pop = 1'b1;
            n.tx_shift = tx_frame(r.ctrl[2:0], r.ctrl[CR_ODD], txq_head);
            n.tx_bit = 4'h0;
            n.tx_phase = TX_START;
          end
        end
        TX_START: begin
          if (r.tx_tick == 5'(OVERSAMPLE - 1)) begin
            n.tx_tick = 5'h00;
            n.tx_phase = TX_BITS;
          end
        end
        TX_BITS: begin
          if (r.tx_tick == 5'(OVERSAMPLE - 1)) begin
            n.tx_tick = 5'h00;
            n.tx_shift = {1'b1, r.tx_shift[8:1]};
            n.tx_bit = r.tx_bit + 4'h1;
            if (r.tx_bit == frame_last(r.ctrl[2:0])) begin
              n.tx_phase = TX_STOP;
            end
          end
        end
        TX_STOP: begin
          // stop length counted in half bits: 0.5, 1, 1.5 or 2
          if (r.tx_tick == stop_last) begin
            n.tx_phase = TX_IDLE;
            n.guard_cnt = r.guard_cfg;
          end
        end
      endcase
    end
    // guard counts down in bit times
    if (bit_tick && r.tx_phase == TX_IDLE && r.guard_cnt != 8'h00) begin
      n.guard_cnt = r.guard_cnt - 8'h01;
    end

    // receiver, only with run and receiver_on_bit
    if (tick) begin
      n.rx_tick = r.rx_tick + 4'h1;
      unique case (r.rx_phase)
        RX_IDLE: begin
          n.rx_tick = 4'h0;
          if (r.ctrl[CR_RX_ON] && !line) begin
            n.rx_phase = RX_START;
          end
        end
        RX_START: begin
          // a start bit gone high by mid-bit is a glitch
          if (r.rx_tick == 4'(HALF_BIT_TICKS - 1) && line) begin
            n.rx_phase = RX_IDLE;
          end else if (r.rx_tick == 4'(OVERSAMPLE - 1)) begin
            n.rx_phase = RX_BITS;
            n.rx_bit = 4'h0;
          end
        end
        RX_BITS: begin
          if (r.rx_tick == 4'(HALF_BIT_TICKS - 1)) begin
            n.rx_shift = {line, r.rx_shift[8:1]};
          end
          if (r.rx_tick == 4'(OVERSAMPLE - 1)) begin
            n.rx_bit = r.rx_bit + 4'h1;
            if (r.rx_bit == frame_last(r.ctrl[2:0])) begin
              n.rx_phase = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          // half stop bit is sampled early so the frame can end on time
          if (r.rx_tick == (r.ctrl[4:3] == 2'h0 ? 4'h3 : 4'(HALF_BIT_TICKS - 1))) begin
            n.rx_phase = RX_IDLE;
            if (r.rxq_cnt < cap) begin
              rx_push = 1'b1;
            end else begin
              // overrun, character dropped; set wins over read clear
              n.lost = 1'b1;
            end
            // card line may stay low after a character
            if (r.ctrl[CR_CARD_MODE]) begin
              n.ctrl[CR_RX_ON] = 1'b0;
            end
            n.gap_cnt = r.gap_cfg;
            n.gap_armed = r.gap_cfg != 8'h00;
            n.idle_gap = 1'b0;
            n.pend_gap = 1'b0;
          end
        end
      endcase
    end

    if (bit_tick && r.gap_armed && n.gap_armed) begin
      if (r.gap_cnt <= 8'h01) begin
        n.gap_armed = 1'b0;
        if (r.rxq_cnt == '0) begin
          n.idle_gap = 1'b1;
        end else begin
          n.pend_gap = 1'b1;
        end
      end else begin
        n.gap_cnt = r.gap_cnt - 8'h01;
      end
    end

    // queue bookkeeping
    n.txq_wr = r.txq_wr + AW'(tx_push);
    n.txq_rd = r.txq_rd + AW'(tx_pop);
    n.txq_cnt = r.txq_cnt + CW'(tx_push) - CW'(tx_pop);
    n.rxq_wr = r.rxq_wr + AW'(rx_push);
    n.rxq_rd = r.rxq_rd + AW'(rx_pop);
    n.rxq_cnt = r.rxq_cnt + CW'(rx_push) - CW'(rx_pop);
    // count faulty entries in and out
    n.ferr_cnt = r.ferr_cnt + CW'(rx_push & ferr_new) - CW'(rx_pop & rxq_head[9]);
    n.perr_cnt = r.perr_cnt + CW'(rx_push & perr_new) - CW'(rx_pop & rxq_head[10]);
    if (wr && paddr == OFS_TX_FLUSH) begin
      n.txq_wr = '0;
      n.txq_rd = '0;
      n.txq_cnt = '0;
    end
    if (wr && paddr == OFS_RX_FLUSH) begin
      n.rxq_wr = '0;
      n.rxq_rd = '0;
      n.rxq_cnt = '0;
      n.ferr_cnt = '0;
      n.perr_cnt = '0;
    end

    txd_now = 1'b1;
    if (run && r.tx_phase == TX_START) begin
      txd_now = 1'b0;
    end else if (run && r.tx_phase == TX_BITS) begin
      txd_now = r.tx_shift[0];
    end
    n.txd = txd_now;
    // open-drain data pulls low only; clock routed with it
    n.data_oe = r.route & !txd_now;
    n.clk_pin = r.route & card_clk;
    n.irq_reg = |(flags[8:0] & r.ier);
    n.rx_meta = card_data_in_pin;
    n.rx_sync = r.rx_meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= STATE_RESET;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata_reg;
  assign pready = r.pready_reg;
  assign pslverr = r.pslverr_reg;
  assign serial_out = r.txd;
  assign card_data_out_oe = r.data_oe;
  assign card_clock_pin = r.clk_pin;
  assign irq = r.irq_reg;
endmodule : uart_sc_core

// ===== sim/uart_sc_assertions.sv
// concurrent checks on the transceiver ports: status reads, pin routing, interrupt, idle line
// assumes an apb master that holds paddr and pwrite until pready is sampled
module uart_sc_checker import uart_sc_pkg::*; #(
  parameter int DEPTH = QUEUE_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic card_data_in_pin,
  input wire logic serial_out,
  input wire logic card_data_out_oe,
  input wire logic card_clock_pin,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_done;
  logic flags_rd;
  logic any_w_reg;
  logic run_seen_reg;
  logic ier_w_reg;
  assign wr_done = psel & penable & pwrite & pready;
  assign flags_rd = psel & penable & !pwrite & pready & (paddr == OFS_FLAGS);
  // history of writes since reset, so reset-time claims can be checked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      any_w_reg <= 1'b0;
      run_seen_reg <= 1'b0;
      ier_w_reg <= 1'b0;
    end else if (wr_done) begin
      any_w_reg <= 1'b1;
      if (paddr == OFS_CTRL && pwdata[CR_RUN]) run_seen_reg <= 1'b1;
      if (paddr == OFS_IER) ier_w_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_flags_reset: assert property (
    flags_rd && !any_w_reg |-> prdata[15:0] == FLAGS_RESET)
    else $error("status read after reset is wrong");
  a_flags_upper_zero: assert property (
    flags_rd |-> prdata[31:10] == 22'h0)
    else $error("status upper bits not zero");
  a_tx_full_free: assert property (
    flags_rd && prdata[SR_TX_FULL] |-> !prdata[SR_TX_HALF_FREE])
    else $error("transmit full and half free together");
  a_rx_half_avail: assert property (
    flags_rd && prdata[SR_RX_HALF] |-> prdata[SR_RX_AVAIL])
    else $error("receive half flag without data");
  a_gap_one_kind: assert property (
    flags_rd |-> !(prdata[SR_IDLE_GAP] && prdata[SR_PEND_GAP]))
    else $error("both gap flags set");
  a_fault_has_entry: assert property (
    flags_rd && (prdata[SR_STOP_FAULT] || prdata[SR_CHECK_FAULT]) |-> prdata[SR_RX_AVAIL])
    else $error("fault flag with empty receive queue");
  // pin and line leave the same register together, so compare in one cycle
  a_oe_follows_out: assert property (
    card_data_out_oe |-> !serial_out)
    else $error("card data pulled low without low serial output");
  a_idle_before_run: assert property (
    !run_seen_reg |-> serial_out)
    else $error("transmit line low before run");
  a_irq_needs_enable: assert property (
    !ier_w_reg |-> !irq)
    else $error("interrupt without any enable written");
endmodule : uart_sc_checker

bind uart_sc_core uart_sc_checker #(.DEPTH(DEPTH)) i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .card_data_in_pin(card_data_in_pin),
  .serial_out(serial_out), .card_data_out_oe(card_data_out_oe),
  .card_clock_pin(card_clock_pin), .irq(irq));

// ===== sim/remote_serial_model.sv
// far-side serial device: sends 8 data + even parity frames, captures 8-bit frames
// assumes baud reload 0, so one bit is OVERSAMPLE pclk cycles
module remote_serial_model import uart_sc_pkg::*; #(
  parameter int BIT_CYCLES = OVERSAMPLE
) (
  input wire logic pclk,
  input wire logic line_in,
  output logic line_out,
  output logic [7:0] last_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  initial line_out = 1'b1;
  // direct convention, one unit per bit
  task automatic send_char(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic [9:0] f;
    f = {(^d) ^ bad_par, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      line_out <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge pclk);
    end
    @(posedge pclk);
    line_out <= ~bad_stop;
    // a broken stop is short so the receiver does not take it for a start
    repeat (BIT_CYCLES / 2 + 1) @(posedge pclk);
    line_out <= 1'b1;
    repeat (2 * BIT_CYCLES) @(posedge pclk);
  endtask : send_char
  initial begin
    last_rx = 8'h00;
    forever begin
      @(posedge pclk);
      if (line_in === 1'b0) begin
        repeat (BIT_CYCLES / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYCLES) @(posedge pclk);
          sh[i] = line_in;
        end
        repeat (2 * BIT_CYCLES) @(posedge pclk);
        last_rx = sh;
      end
    end
  end
endmodule : remote_serial_model

// ===== sim/uart_status_fifo_smartcard_bench.sv
// bench for the transceiver: apb tasks, far-side model on the card data line
// assumes the core answers each apb access with one wait state; card line has a pull-up
module uart_status_fifo_smartcard_bench import uart_sc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic serial_out, card_data_out_oe, card_clock_pin, irq, far_line, card_line;
  logic [7:0] paddr, last_rx;
  logic [31:0] pwdata, prdata, rd;
  int fail_count = 0;
  int check_count = 0;
  int n;
  assign card_line = far_line & ~card_data_out_oe;
  uart_sc_core #(.DEPTH(QUEUE_DEPTH)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .card_data_in_pin(card_line),
    .serial_out(serial_out), .card_data_out_oe(card_data_out_oe),
    .card_clock_pin(card_clock_pin), .irq(irq));
  remote_serial_model i_far (.pclk(pclk), .line_in(serial_out), .line_out(far_line),
    .last_rx(last_rx));
  always #5 pclk = ~pclk;
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      fail_count++;
      end_sim();
    end
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rdm
  // waits for a card clock level, counting pclk cycles in n; bounded
  task lvl(input logic v);
    int k;
    k = 0;
    while (card_clock_pin !== v && k < 100) begin
      @(posedge pclk);
      n++;
      k++;
    end
    if (k >= 100) begin
      fail_count++;
      end_sim();
    end
  endtask : lvl
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdm(OFS_FLAGS, 32'hffffffff, 32'h6);
    wr(OFS_FLAGS, 32'hffff);
    rdm(OFS_FLAGS, 32'hffffffff, 32'h6);
    rdm(OFS_GUARD, 32'hffffffff, 32'h0);
    rdm(OFS_GAP, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(OFS_BAUD, 32'h0);
    // queue filled with the baud generator stopped so nothing drains
    wr(OFS_CTRL, 32'h517);
    for (int i = 1; i <= 16; i++) begin
      wr(OFS_TX_HOLD, 32'(i));
      if (i == 8) rdm(OFS_FLAGS, 32'hffffffff, 32'h006);
      if (i == 9) rdm(OFS_FLAGS, 32'hffffffff, 32'h002);
    end
    rdm(OFS_FLAGS, 32'hffffffff, 32'h202);
    chk({31'h0, serial_out}, 32'h1);
    wr(OFS_TX_FLUSH, 32'h0);
    rdm(OFS_FLAGS, 32'hffffffff, 32'h006);
    wr(OFS_CTRL, 32'h597);
    wr(OFS_IER, 32'h1);
    for (int i = 0; i < 9; i++) i_far.send_char(8'h30 + 8'(i), i == 0, i == 1);
    rdm(OFS_FLAGS, 32'hffffffff, 32'h11f);
    chk({31'h0, irq}, 32'h1);
    rdm(OFS_RX_HOLD, 32'h2ff, 32'h030);
    rdm(OFS_FLAGS, 32'hffffffff, 32'h017);
    rdm(OFS_RX_HOLD, 32'h2ff, 32'h231);
    rdm(OFS_FLAGS, 32'hffffffff, 32'h007);
    wr(OFS_RX_FLUSH, 32'h5a);
    rdm(OFS_FLAGS, 32'hffffffff, 32'h006);
    for (int i = 0; i < 17; i++) i_far.send_char(8'h40 + 8'(i), 1'b0, 1'b0);
    rdm(OFS_FLAGS, 32'hffffffff, 32'h127);
    rdm(OFS_FLAGS, 32'hffffffff, 32'h107);
    wr(OFS_RX_FLUSH, 32'h0);
    wr(OFS_GAP, 32'h2);
    i_far.send_char(8'h11, 1'b0, 1'b0);
    repeat (100) @(posedge pclk);
    rdm(OFS_FLAGS, 32'hffffffff, 32'h047);
    rdm(OFS_RX_HOLD, 32'hff, 32'h11);
    // a two-bit limit runs out before the model lets go, so the queue would not be empty yet
    wr(OFS_GAP, 32'h8);
    i_far.send_char(8'h22, 1'b0, 1'b0);
    rdm(OFS_RX_HOLD, 32'hff, 32'h22);
    repeat (120) @(posedge pclk);
    rdm(OFS_FLAGS, 32'hffffffff, 32'h086);
    wr(OFS_GUARD, 32'h3);
    wr(OFS_TX_HOLD, 32'ha5);
    rdm(OFS_FLAGS, 32'h2, 32'h0);
    repeat (200) @(posedge pclk);
    rdm(OFS_FLAGS, 32'h2, 32'h0);
    repeat (60) @(posedge pclk);
    rdm(OFS_FLAGS, 32'h2, 32'h2);
    chk({24'h0, last_rx}, 32'ha5);
    wr(OFS_ROUTE, 32'h1);
    wr(OFS_CARD_DIV, 32'h2);
    lvl(1'b0);
    lvl(1'b1);
    n = 0;
    lvl(1'b0);
    lvl(1'b1);
    chk(32'(n), 32'h4);
    wr(OFS_CTRL, 32'h797);
    wr(OFS_TX_HOLD, 32'h3c);
    repeat (260) @(posedge pclk);
    rdm(OFS_CTRL, 32'hffffffff, 32'h697);
    rdm(OFS_RX_HOLD, 32'hff, 32'h3c);
    end_sim();
  end
endmodule : uart_status_fifo_smartcard_bench
